// ==== src/csi_axil.v ====
`timescale 1ns/10ps
`include "csi_defines.vh"
module csi_axil (
  input wire i_clk,
  input wire i_rst,
  input wire [7:0] i_awaddr,
  input wire i_awvalid,
  output wire o_awready,
  input wire [31:0] i_wdata,
  input wire [3:0] i_wstrb,
  input wire i_wvalid,
  output wire o_wready,
  output wire [1:0] o_bresp,
  output wire o_bvalid,
  input wire i_bready,
  input wire [7:0] i_araddr,
  input wire i_arvalid,
  output wire o_arready,
  output wire [31:0] o_rdata,
  output wire [1:0] o_rresp,
  output wire o_rvalid,
  input wire i_rready,
  output wire o_wr_en,
  output wire [7:0] o_wr_addr,
  output wire [31:0] o_wr_data,
  output wire [3:0] o_wr_strb,
  input wire i_wr_err,
  output wire o_rd_en,
  output wire [7:0] o_rd_addr,
  input wire [31:0] i_rd_data,
  input wire i_rd_err
);
  reg aw_full_q;
  reg [7:0] aw_addr_q;
  reg w_full_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;
  reg bvalid_q;
  reg [1:0] bresp_q;
  reg rvalid_q;
  reg [31:0] rdata_q;
  reg [1:0] rresp_q;

  assign o_awready = ~aw_full_q & ~bvalid_q;
  assign o_wready = ~w_full_q & ~bvalid_q;
  assign o_wr_en = aw_full_q & w_full_q & ~bvalid_q;
  assign o_wr_addr = aw_addr_q;
  assign o_wr_data = w_data_q;
  assign o_wr_strb = w_strb_q;
  assign o_bvalid = bvalid_q;
  assign o_bresp = bresp_q;
  assign o_arready = ~rvalid_q;
  assign o_rd_en = i_arvalid & ~rvalid_q;
  assign o_rd_addr = i_araddr;
  assign o_rvalid = rvalid_q;
  assign o_rdata = rdata_q;
  assign o_rresp = rresp_q;

  always @(posedge i_clk) begin
    if (i_rst) begin
      aw_full_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_full_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= `CSI_RESP_OK;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `CSI_RESP_OK;
    end else begin
      if (i_awvalid && o_awready) begin
        aw_full_q <= 1'b1;
        aw_addr_q <= i_awaddr;
      end
      if (i_wvalid && o_wready) begin
        w_full_q <= 1'b1;
        w_data_q <= i_wdata;
        w_strb_q <= i_wstrb;
      end
      if (o_wr_en) begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= i_wr_err ? `CSI_RESP_ERR : `CSI_RESP_OK;
      end else if (bvalid_q && i_bready) begin
        bvalid_q <= 1'b0;
      end
      if (o_rd_en) begin
        rvalid_q <= 1'b1;
        rdata_q <= i_rd_err ? 32'h0000_0000 : i_rd_data;
        rresp_q <= i_rd_err ? `CSI_RESP_ERR : `CSI_RESP_OK;
      end else if (rvalid_q && i_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end
endmodule // csi_axil

// ==== src/csi_defines.vh ====
// Functional notes
// - Serial input sampled on falling bit clock edge, rising when edge select set.
// - Transfer starts one bit after sync, or same bit when justify set.
// - Enabled transmit slot loads current shadow word, then pointer advances.
// - Disabled transmit slot drives low, or tri-states when idle mode set.
// - Slot enables beyond the configured frame length are ignored.
// - Transmit words are left justified; unused low bits never sent.
// - Enabled receive slot writes shift register into current shadow, pointer advances.
// - Each received word stored left justified in its own location.
// - Master emits sync on frame counter reset; slave sync resets counter.
// - After last slot of a frame, buffering stops until next sync.
// - Shared pointer advances once per slot enabled for transmit or receive.
// - Pointer equal to length field resets it and exchanges all shadows.
// - Each shadow exchange raises a processor interrupt.
// - Transmit empty sets at exchange, clears on any transmit buffer write.
// - Underflow sets at exchange for unwritten used buffer, clears on rewrite.
// - Only buffer locations in use affect underflow, receive full and overflow flags.
// - Receive full shows new data, clears after every used buffer read.
// - Unread receive location is overwritten, sets overflow, cleared by reading it.
// - Four bit slot field shows the current frame counter value.
// - Loopback routes serial output into input path, ignoring input pin.
// - Underflowed slot sends zero, or repeats last written word in repeat mode.
// - Word size field holds word length minus one.
// - Slave ignores further sync pulses until the current frame finishes.
`ifndef CSI_DEFINES_VH
`define CSI_DEFINES_VH
`define CSI_ADDR_CTRL 8'h00
`define CSI_ADDR_CFG 8'h04
`define CSI_ADDR_STAT 8'h08
`define CSI_ADDR_TSE 8'h0c
`define CSI_ADDR_RSE 8'h10
`define CSI_ADDR_RXBUF0 8'h14
`define CSI_ADDR_TXBUF0 8'h24
`define CSI_ADDR_LAST 8'h30
`define CSI_CTRL_LOOP 11
`define CSI_CTRL_EDGE 9
`define CSI_CTRL_DIR 8
`define CSI_CTRL_UNDERFLOW_REPEAT_MODE 7
`define CSI_CTRL_TRI 6
`define CSI_CTRL_JUST 5
`define CSI_CFG_BUFFER_LENGTH_LSB 10
`define CSI_CFG_FLEN_LSB 4
`define CSI_CFG_WS_LSB 0
`define CSI_STAT_SLOT_LSB 8
`define CSI_STAT_ROV 3
`define CSI_STAT_RECEIVE_FULL_FLAG 2
`define CSI_STAT_TRANSMIT_UNDERFLOW_FLAG 1
`define CSI_STAT_TRANSMIT_EMPTY_FLAG 0
`define CSI_RST_REG 16'h0000
`define CSI_RESP_OK 2'b00
`define CSI_RESP_ERR 2'b10
`endif

// ==== src/csi_sync2.v ====
`timescale 1ns/10ps
module csi_sync2 #(
  parameter W = 3
) (
  input wire i_clk,
  input wire i_rst,
  input wire [W-1:0] i_d,
  output wire [W-1:0] o_q
);
  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  always @(posedge i_clk) begin
    if (i_rst) begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
    end else begin
      meta_q <= i_d;
      sync_q <= meta_q;
    end
  end

  assign o_q = sync_q;
endmodule // csi_sync2

// ==== src/csi_top.v ====
`timescale 1ns/10ps
`include "csi_defines.vh"
module csi_top (
  input wire I_CLOCK,
  input wire I_RESET,
  input wire [7:0] I_AWADDR,
  input wire I_AWVALID,
  output wire O_AWREADY,
  input wire [31:0] I_WDATA,
  input wire [3:0] I_WSTRB,
  input wire I_WVALID,
  output wire O_WREADY,
  output wire [1:0] O_BRESP,
  output wire O_BVALID,
  input wire I_BREADY,
  input wire [7:0] I_ARADDR,
  input wire I_ARVALID,
  output wire O_ARREADY,
  output wire [31:0] O_RDATA,
  output wire [1:0] O_RRESP,
  output wire O_RVALID,
  input wire I_RREADY,
  input wire I_BIT_CLOCK,
  input wire I_FRAME_SYNC,
  output wire O_FRAME_SYNC,
  output wire O_FRAME_SYNC_OE,
  input wire I_SERIAL_IN,
  output wire O_SERIAL_OUT,
  output wire O_SERIAL_OUT_OE,
  output wire O_IRQ
);
  // ****************************************************************
  // Register bus
  // ****************************************************************
  wire wr_en;
  wire [7:0] wr_addr;
  wire [31:0] wr_data;
  wire [3:0] wr_strb;
  wire rd_en;
  wire [7:0] rd_addr;
  reg [31:0] rd_data;
  wire wr_err;
  wire rd_err;

  csi_axil u_axil (
    .i_clk(I_CLOCK),
    .i_rst(I_RESET),
    .i_awaddr(I_AWADDR),
    .i_awvalid(I_AWVALID),
    .o_awready(O_AWREADY),
    .i_wdata(I_WDATA),
    .i_wstrb(I_WSTRB),
    .i_wvalid(I_WVALID),
    .o_wready(O_WREADY),
    .o_bresp(O_BRESP),
    .o_bvalid(O_BVALID),
    .i_bready(I_BREADY),
    .i_araddr(I_ARADDR),
    .i_arvalid(I_ARVALID),
    .o_arready(O_ARREADY),
    .o_rdata(O_RDATA),
    .o_rresp(O_RRESP),
    .o_rvalid(O_RVALID),
    .i_rready(I_RREADY),
    .o_wr_en(wr_en),
    .o_wr_addr(wr_addr),
    .o_wr_data(wr_data),
    .o_wr_strb(wr_strb),
    .i_wr_err(wr_err),
    .o_rd_en(rd_en),
    .o_rd_addr(rd_addr),
    .i_rd_data(rd_data),
    .i_rd_err(rd_err)
  );

  // Only aligned words up to the last register exist.
  assign wr_err = (wr_addr[1:0] != 2'h0) || (wr_addr > `CSI_ADDR_LAST);
  assign rd_err = (rd_addr[1:0] != 2'h0) || (rd_addr > `CSI_ADDR_LAST);

  reg [15:0] ctrl_q;
  reg [15:0] cfg_q;
  reg [15:0] tse_q;
  reg [15:0] rse_q;

  // Byte strobes apply to the two low lanes; upper lanes hold nothing.
  function [15:0] merge;
    input [15:0] old;
    input [31:0] data;
    input [3:0] strb;
    begin
      merge = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
    end
  endfunction

  wire wr_ok = wr_en & ~wr_err;
  wire lanes = |wr_strb[1:0];

  always @(posedge I_CLOCK) begin
    if (I_RESET) begin
      ctrl_q <= `CSI_RST_REG;
      cfg_q <= `CSI_RST_REG;
      tse_q <= `CSI_RST_REG;
      rse_q <= `CSI_RST_REG;
    end else if (wr_ok) begin
      case (wr_addr)
        `CSI_ADDR_CTRL: ctrl_q <= merge(ctrl_q, wr_data, wr_strb);
        `CSI_ADDR_CFG: cfg_q <= merge(cfg_q, wr_data, wr_strb);
        `CSI_ADDR_TSE: tse_q <= merge(tse_q, wr_data, wr_strb);
        `CSI_ADDR_RSE: rse_q <= merge(rse_q, wr_data, wr_strb);
        default: ctrl_q <= ctrl_q;
      endcase
    end
  end

  wire loop_en = ctrl_q[`CSI_CTRL_LOOP];
  wire edge_sel = ctrl_q[`CSI_CTRL_EDGE];
  wire sync_slave = ctrl_q[`CSI_CTRL_DIR];
  wire unf_repeat = ctrl_q[`CSI_CTRL_UNDERFLOW_REPEAT_MODE];
  wire idle_tri = ctrl_q[`CSI_CTRL_TRI];
  wire justify = ctrl_q[`CSI_CTRL_JUST];
  wire [1:0] buffer_length = cfg_q[`CSI_CFG_BUFFER_LENGTH_LSB +: 2];
  wire [3:0] flen = cfg_q[`CSI_CFG_FLEN_LSB +: 4];
  wire [3:0] ws = cfg_q[`CSI_CFG_WS_LSB +: 4];

  // ****************************************************************
  // Link pins and edge detection
  // ****************************************************************
  wire [2:0] pins_s;
  reg bclk_prev_q;

  csi_sync2 #(.W(3)) u_sync (
    .i_clk(I_CLOCK),
    .i_rst(I_RESET),
    .i_d({I_SERIAL_IN, I_FRAME_SYNC, I_BIT_CLOCK}),
    .o_q(pins_s)
  );

  always @(posedge I_CLOCK) begin
    if (I_RESET) begin
      bclk_prev_q <= 1'b0;
    end else begin
      bclk_prev_q <= pins_s[0];
    end
  end

  wire bclk_rise = pins_s[0] & ~bclk_prev_q;
  wire bclk_fall = ~pins_s[0] & bclk_prev_q;
  // The edge that samples is the opposite of the edge that drives.
  wire smp = edge_sel ? bclk_rise : bclk_fall;
  wire drv = edge_sel ? bclk_fall : bclk_rise;

  // ****************************************************************
  // Frame and slot sequencing
  // ****************************************************************
  reg running_q;
  reg [3:0] bit_q;
  reg [3:0] slot_q;
  reg [1:0] ptr_q;
  reg fs_out_q;
  reg sdo_q;
  reg sdo_oe_q;
  reg [15:0] tx_sh_q;
  reg [15:0] rx_sh_q;
  reg irq_q;

  wire fs_now = sync_slave ? pins_s[1] : fs_out_q;
  wire sdi_eff = loop_en ? sdo_q : pins_s[2];
  wire last_slot_bit = (bit_q == ws) && (slot_q == flen);
  // A sync while a frame runs is honoured only at its final bit, and never when justify is set.
  wire hit = fs_now & (~running_q | (~justify & last_slot_bit));
  wire hit_now = hit & justify;
  wire cur_run = running_q | hit_now;
  wire [3:0] cur_bit = hit_now ? 4'h0 : bit_q;
  wire [3:0] cur_slot = hit_now ? 4'h0 : slot_q;
  wire complete = smp & cur_run & (cur_bit == ws);
  wire t_en = tse_q[cur_slot];
  wire r_en = rse_q[cur_slot];
  wire use_slot = complete & (t_en | r_en);
  wire xchg = use_slot & (ptr_q == buffer_length);
  wire [15:0] rx_sh_d = {rx_sh_q[14:0], sdi_eff};
  wire [15:0] rx_word = rx_sh_d << (4'hf - ws);

  always @(posedge I_CLOCK) begin
    if (I_RESET) begin
      running_q <= 1'b0;
      bit_q <= 4'h0;
      slot_q <= 4'h0;
      ptr_q <= 2'h0;
      rx_sh_q <= 16'h0000;
      irq_q <= 1'b0;
    end else begin
      irq_q <= xchg;
      if (smp) begin
        rx_sh_q <= rx_sh_d;
        if (hit && !justify) begin
          running_q <= 1'b1;
          bit_q <= 4'h0;
          slot_q <= 4'h0;
        end else if (complete) begin
          bit_q <= 4'h0;
          if (cur_slot == flen) begin
            running_q <= 1'b0;
          end else begin
            running_q <= 1'b1;
            slot_q <= cur_slot + 4'h1;
          end
        end else if (cur_run) begin
          running_q <= 1'b1;
          bit_q <= cur_bit + 4'h1;
          slot_q <= cur_slot;
        end
      end
      if (use_slot) begin
        ptr_q <= xchg ? 2'h0 : ptr_q + 2'h1;
      end
    end
  end

  // ****************************************************************
  // Buffer entries
  // ****************************************************************
  wire [63:0] txsh_w;
  wire [63:0] transmit_buffer_w;
  wire [63:0] receive_buffer_w;
  wire [3:0] tx_unf_w;
  wire [3:0] rx_new_w;
  wire [3:0] rx_ovf_w;
  wire [3:0] in_use;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_ent
      reg [15:0] transmit_buffer_q;
      reg [15:0] txsh_q;
      reg [15:0] rxsh_q;
      reg [15:0] receive_buffer_q;
      reg tx_wr_q;
      reg tx_unf_q;
      reg rx_new_q;
      reg rx_ovf_q;
      wire [31:0] tx_addr_w = `CSI_ADDR_TXBUF0 + gi * 4;
      wire [31:0] rx_addr_w = `CSI_ADDR_RXBUF0 + gi * 4;
      wire [7:0] tx_addr = tx_addr_w[7:0];
      wire [7:0] rx_addr = rx_addr_w[7:0];
      wire tx_write = wr_ok & lanes & (wr_addr == tx_addr);
      wire rx_read = rd_en & ~rd_err & (rd_addr == rx_addr);
      wire store = use_slot & r_en & (ptr_q == gi);
      wire used = (gi <= buffer_length);

      always @(posedge I_CLOCK) begin
        if (I_RESET) begin
          transmit_buffer_q <= `CSI_RST_REG;
          txsh_q <= `CSI_RST_REG;
          rxsh_q <= `CSI_RST_REG;
          receive_buffer_q <= `CSI_RST_REG;
          tx_wr_q <= 1'b0;
          tx_unf_q <= 1'b0;
          rx_new_q <= 1'b0;
          rx_ovf_q <= 1'b0;
        end else begin
          if (tx_write) begin
            transmit_buffer_q <= merge(transmit_buffer_q, wr_data, wr_strb);
          end
          if (store) begin
            rxsh_q <= rx_word;
          end
          if (tx_write) begin
            tx_unf_q <= 1'b0;
          end
          if (rx_read) begin
            rx_new_q <= 1'b0;
            rx_ovf_q <= 1'b0;
          end
          // Exchange comes after the clears so that it wins over a coincident clear, except that a coincident read keeps overflow clear.
          if (xchg) begin
            txsh_q <= (!tx_wr_q && !unf_repeat) ? 16'h0000 : transmit_buffer_q;
            receive_buffer_q <= store ? rx_word : rxsh_q;
            if (used && !tx_wr_q) begin
              tx_unf_q <= 1'b1;
            end
            if (used) begin
              rx_new_q <= 1'b1;
            end
            if (used && rx_new_q && !rx_read) begin
              rx_ovf_q <= 1'b1;
            end
          end
          // A write in the exchange cycle counts for the next exchange.
          if (tx_write) begin
            tx_wr_q <= 1'b1;
          end else if (xchg) begin
            tx_wr_q <= 1'b0;
          end
        end
      end

      assign txsh_w[gi*16 +: 16] = txsh_q;
      assign transmit_buffer_w[gi*16 +: 16] = transmit_buffer_q;
      assign receive_buffer_w[gi*16 +: 16] = receive_buffer_q;
      assign tx_unf_w[gi] = tx_unf_q;
      assign rx_new_w[gi] = rx_new_q;
      assign rx_ovf_w[gi] = rx_ovf_q;
      assign in_use[gi] = used;
    end
  endgenerate

  // ****************************************************************
  // Status flags
  // ****************************************************************
  reg transmit_empty_flag_q;
  wire any_tx_write = wr_ok & lanes & (wr_addr >= `CSI_ADDR_TXBUF0);

  always @(posedge I_CLOCK) begin
    if (I_RESET) begin
      transmit_empty_flag_q <= 1'b0;
    end else if (xchg) begin
      transmit_empty_flag_q <= 1'b1;
    end else if (any_tx_write) begin
      transmit_empty_flag_q <= 1'b0;
    end
  end

  wire transmit_underflow_flag = |(tx_unf_w & in_use);
  wire receive_full_flag = |(rx_new_w & in_use);
  wire receive_overflow_flag = |(rx_ovf_w & in_use);

  // ****************************************************************
  // Transmit path
  // ****************************************************************
  wire load = (running_q && bit_q == 4'h0) || (!running_q && justify);
  wire [3:0] ld_slot = running_q ? slot_q : 4'h0;
  wire ld_en = tse_q[ld_slot];
  wire [15:0] ld_word = txsh_w[ptr_q*16 +: 16];

  always @(posedge I_CLOCK) begin
    if (I_RESET) begin
      fs_out_q <= 1'b0;
      sdo_q <= 1'b0;
      sdo_oe_q <= 1'b1;
      tx_sh_q <= 16'h0000;
    end else if (drv) begin
      // The sync lands on the last bit, or on the first bit when justified.
      fs_out_q <= ~sync_slave & (~running_q | (~justify & last_slot_bit));
      if (load) begin
        sdo_q <= ld_en & ld_word[15];
        tx_sh_q <= ld_en ? {ld_word[14:0], 1'b0} : 16'h0000;
        sdo_oe_q <= ld_en | ~idle_tri;
      end else if (running_q) begin
        sdo_q <= tx_sh_q[15];
        tx_sh_q <= {tx_sh_q[14:0], 1'b0};
      end else begin
        sdo_q <= 1'b0;
        sdo_oe_q <= ~idle_tri;
      end
    end
  end

  // ****************************************************************
  // Read data
  // ****************************************************************
  // Both buffer banks start one word above a four-word boundary, so the entry is the word offset less one.
  wire [1:0] buf_idx = rd_addr[3:2] - 2'h1;

  always @* begin
    rd_data = 32'h0000_0000;
    case (rd_addr)
      `CSI_ADDR_CTRL: rd_data[15:0] = ctrl_q;
      `CSI_ADDR_CFG: rd_data[15:0] = cfg_q;
      `CSI_ADDR_STAT: rd_data[15:0] = {4'h0, slot_q, 4'h0, receive_overflow_flag, receive_full_flag, transmit_underflow_flag, transmit_empty_flag_q};
      `CSI_ADDR_TSE: rd_data[15:0] = tse_q;
      `CSI_ADDR_RSE: rd_data[15:0] = rse_q;
      default: begin
        if (rd_addr >= `CSI_ADDR_TXBUF0) begin
          rd_data[15:0] = transmit_buffer_w[buf_idx*16 +: 16];
        end else if (rd_addr >= `CSI_ADDR_RXBUF0) begin
          rd_data[15:0] = receive_buffer_w[buf_idx*16 +: 16];
        end
      end
    endcase
  end

  assign O_FRAME_SYNC = fs_out_q;
  assign O_FRAME_SYNC_OE = ~ctrl_q[`CSI_CTRL_DIR];
  assign O_SERIAL_OUT = sdo_q;
  assign O_SERIAL_OUT_OE = sdo_oe_q;
  assign O_IRQ = irq_q;
endmodule // csi_top

// ==== tb/csi_codec.sv ====
`timescale 1ns/10ps
module csi_codec (
  input wire i_run,
  input wire i_just,
  input wire i_rise,
  input wire i_sdo,
  input wire i_fs,
  input wire [4:0] i_bits,
  input wire [15:0] i_pat,
  output reg o_bclk,
  output reg o_sdi,
  output reg [15:0] o_word
);
  // ****************************************
  // Codec side of the frame link.
  // ****************************************
  reg [15:0] sh;
  integer n;
  // When the block samples on rising edges, the codec does all its work on falling edges.
  wire ck = o_bclk ^ i_rise;
  initial begin
    o_bclk = 1'h0;
    o_sdi = 1'h0;
    o_word = 16'h0000;
    sh = 16'h0000;
    n = 31;
  end
  // The odd start offset keeps the bit clock out of phase with the system clock.
  initial begin
    #7;
    forever begin
      #160;
      if (i_run) o_bclk = ~o_bclk;
    end
  end
  // The block's outputs lag the pin by several system clocks, so its lines are taken late in each bit.
  always @(posedge ck) begin
    if (i_fs && i_just) n = 0;
    if (n < i_bits) begin
      sh = {sh[14:0], i_sdo};
      n = n + 1;
      if (n == i_bits) o_word = sh << (16 - i_bits);
    end
    if (i_fs && !i_just) n = 0;
    o_sdi = (n < i_bits) ? i_pat[15 - n] : ~o_sdi;
  end
endmodule // csi_codec

// ==== tb/csi_top_checker.sv ====
`timescale 1ns/10ps
module csi_chk (
  input wire I_CLOCK,
  input wire I_RESET,
  input wire I_AWVALID,
  input wire O_AWREADY,
  input wire I_WVALID,
  input wire O_WREADY,
  input wire [1:0] O_BRESP,
  input wire O_BVALID,
  input wire I_BREADY,
  input wire I_ARVALID,
  input wire O_ARREADY,
  input wire [31:0] O_RDATA,
  input wire O_RVALID,
  input wire I_RREADY,
  input wire O_FRAME_SYNC,
  input wire O_FRAME_SYNC_OE,
  input wire O_SERIAL_OUT,
  input wire O_IRQ
);
  // ****************************************
  // Bus and link properties.
  // ****************************************
  default clocking cb @(posedge I_CLOCK);
  endclocking
  default disable iff (I_RESET);
  sequence s_taken;
    I_AWVALID && O_AWREADY && I_WVALID && O_WREADY;
  endsequence
  sequence s_answer;
    ##2 O_BVALID;
  endsequence
  chk_write_answer: assert property (s_taken |-> s_answer)
    else $error("write response late");
  chk_read_answer: assert property (I_ARVALID && O_ARREADY |=> O_RVALID)
    else $error("read response late");
  chk_bresp_holds: assert property (O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP))
    else $error("write response dropped");
  chk_rdata_holds: assert property (O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA))
    else $error("read response dropped");
  chk_ar_refused: assert property (O_RVALID |-> !O_ARREADY)
    else $error("read address taken while busy");
  chk_aw_refused: assert property (O_BVALID |-> !O_AWREADY && !O_WREADY)
    else $error("write taken while busy");
  chk_irq_pulse: assert property (O_IRQ |=> !O_IRQ)
    else $error("interrupt longer than one cycle");
  chk_sync_driven: assert property (O_FRAME_SYNC |-> O_FRAME_SYNC_OE)
    else $error("frame sync pulse not driven");
  chk_bit_holds: assert property ($changed(O_SERIAL_OUT) |=> $stable(O_SERIAL_OUT) [*5])
    else $error("serial bit shorter than a bit period");
endmodule // csi_chk
bind csi_top csi_chk chk_u (.I_CLOCK(I_CLOCK), .I_RESET(I_RESET), .I_AWVALID(I_AWVALID),
  .O_AWREADY(O_AWREADY), .I_WVALID(I_WVALID), .O_WREADY(O_WREADY), .O_BRESP(O_BRESP),
  .O_BVALID(O_BVALID), .I_BREADY(I_BREADY), .I_ARVALID(I_ARVALID), .O_ARREADY(O_ARREADY),
  .O_RDATA(O_RDATA), .O_RVALID(O_RVALID), .I_RREADY(I_RREADY), .O_FRAME_SYNC(O_FRAME_SYNC),
  .O_FRAME_SYNC_OE(O_FRAME_SYNC_OE), .O_SERIAL_OUT(O_SERIAL_OUT), .O_IRQ(O_IRQ));

// ==== tb/tb.sv ====
`timescale 1ns/10ps
`include "csi_defines.vh"
module tb;
  // ****************************************
  // Stimulus and checks.
  // ****************************************
  localparam [1:0] ok = `CSI_RESP_OK;
  reg clk = 1'h0, rst = 1'h1, run = 1'h0, just = 1'h0, rise = 1'h0;
  reg awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  reg [7:0] awaddr = 8'h00, araddr = 8'h00;
  reg [31:0] wdata = 32'h00000000;
  reg [4:0] bits = 5'h10;
  reg [15:0] pat = 16'h9600, v;
  integer err_total = 0, num_checks = 0, i;
  wire awready, wready, bvalid, arready, rvalid, fso, fs_oe, sdo, sdo_oe, irq, bclk, sdi;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [15:0] word;
  wire sdo_pin = sdo_oe ? sdo : 1'hz;
  always #20 clk = ~clk;
  csi_top dut_u (.I_CLOCK(clk), .I_RESET(rst), .I_AWADDR(awaddr), .I_AWVALID(awvalid), .O_AWREADY(awready),
    .I_WDATA(wdata), .I_WSTRB(4'h3), .I_WVALID(wvalid), .O_WREADY(wready), .O_BRESP(bresp), .O_BVALID(bvalid),
    .I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready), .O_RDATA(rdata),
    .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready), .I_BIT_CLOCK(bclk), .I_FRAME_SYNC(1'h0),
    .O_FRAME_SYNC(fso), .O_FRAME_SYNC_OE(fs_oe), .I_SERIAL_IN(sdi), .O_SERIAL_OUT(sdo),
    .O_SERIAL_OUT_OE(sdo_oe), .O_IRQ(irq));
  csi_codec codec_u (.i_run(run), .i_just(just), .i_rise(rise), .i_sdo(sdo_pin), .i_fs(fso), .i_bits(bits), .i_pat(pat),
    .o_bclk(bclk), .o_sdi(sdi), .o_word(word));
  task cmp(input string nm, input [15:0] e, input [15:0] g);
    begin
      num_checks = num_checks + 1;
      if (g !== e) begin
        err_total = err_total + 1;
        $display("BAD %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task wr(input [7:0] a, input [15:0] d, input [1:0] e);
    integer n;
    reg da, dw;
    begin
      @(posedge clk);
      awaddr <= a;
      wdata <= {16'h0000, d};
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      da = 1'h0;
      dw = 1'h0;
      for (n = 0; n < 99 && !(da && dw); n = n + 1) begin
        @(posedge clk);
        if (awready === 1'h1) begin
          awvalid <= 1'h0;
          da = 1'h1;
        end
        if (wready === 1'h1) begin
          wvalid <= 1'h0;
          dw = 1'h1;
        end
      end
      for (n = 0; n < 99 && bvalid !== 1'h1; n = n + 1) @(posedge clk);
      cmp("bvalid", 16'h0001, {15'h0000, bvalid});
      bready <= 1'h1;
      @(posedge clk);
      bready <= 1'h0;
      cmp("bresp", {14'h0000, e}, {14'h0000, bresp});
    end
  endtask
  task rd(input [7:0] a, output [15:0] d, input [1:0] e);
    integer n;
    begin
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'h1;
      @(posedge clk);
      for (n = 0; n < 99 && arready !== 1'h1; n = n + 1) @(posedge clk);
      arvalid <= 1'h0;
      for (n = 0; n < 99 && rvalid !== 1'h1; n = n + 1) @(posedge clk);
      cmp("rvalid", 16'h0001, {15'h0000, rvalid});
      rready <= 1'h1;
      @(posedge clk);
      rready <= 1'h0;
      d = rdata[15:0];
      cmp("rdata upper", 16'h0000, rdata[31:16]);
      cmp("rresp", {14'h0000, e}, {14'h0000, rresp});
    end
  endtask
  task irqs(input integer k);
    integer j, n;
    begin
      for (j = 0; j < k; j = j + 1) begin
        for (n = 0; n < 3000 && irq !== 1'h1; n = n + 1) @(posedge clk);
        cmp("interrupt", 16'h0001, {15'h0000, irq});
        @(posedge clk);
      end
    end
  endtask
  task t_regs;
    begin
      for (i = 0; i < 20; i = i + 4) begin
        rd(i[7:0], v, ok);
        cmp("reset value", `CSI_RST_REG, v);
      end
      wr(`CSI_ADDR_TSE, 16'h8001, ok);
      rd(`CSI_ADDR_TSE, v, ok);
      cmp("transmit_slot_enables", 16'h8001, v);
      wr(8'h34, 16'h0001, `CSI_RESP_ERR);
      rd(8'h34, v, `CSI_RESP_ERR);
      rd(8'h06, v, `CSI_RESP_ERR);
      cmp("sync enable", 16'h0001, {15'h0000, fs_oe});
    end
  endtask
  task t_loop;
    begin
      wr(`CSI_ADDR_CFG, 16'h000f, ok);
      wr(`CSI_ADDR_RSE, 16'h0001, ok);
      wr(`CSI_ADDR_TXBUF0, 16'ha5c3, ok);
      wr(`CSI_ADDR_CTRL, 16'h0880, ok);
      run <= 1'h1;
      irqs(4);
      cmp("serial word", 16'ha5c3, word);
      rd(`CSI_ADDR_STAT, v, ok);
      cmp("status", 16'h000f, v & 16'h0f0f);
      rd(`CSI_ADDR_RXBUF0, v, ok);
      cmp("loop word", 16'ha5c3, v);
      wr(`CSI_ADDR_TXBUF0, 16'h5a3c, ok);
      rd(`CSI_ADDR_STAT, v, ok);
      cmp("status", 16'h0000, v & 16'h000f);
    end
  endtask
  task t_zero;
    begin
      wr(`CSI_ADDR_CTRL, 16'h0800, ok);
      irqs(3);
      cmp("silent word", 16'h0000, word);
      rd(`CSI_ADDR_STAT, v, ok);
      cmp("underflow", 16'h0002, v & 16'h0002);
    end
  endtask
  task t_pin;
    begin
      bits <= 5'h08;
      wr(`CSI_ADDR_CTRL, 16'h0080, ok);
      wr(`CSI_ADDR_CFG, 16'h0007, ok);
      wr(`CSI_ADDR_TXBUF0, 16'hc3ff, ok);
      irqs(4);
      cmp("short word", 16'hc300, word);
      rd(`CSI_ADDR_RXBUF0, v, ok);
      cmp("pin word", 16'h9600, v);
      just <= 1'h1;
      wr(`CSI_ADDR_CTRL, 16'h00a0, ok);
      irqs(4);
      cmp("justified word", 16'hc300, word);
    end
  endtask
  // The bit clock is stopped while the sampling edge flips, so no bit is cut short.
  task t_rise;
    begin
      run <= 1'h0;
      repeat (20) @(posedge clk);
      just <= 1'h0;
      rise <= 1'h1;
      wr(`CSI_ADDR_CTRL, 16'h0280, ok);
      run <= 1'h1;
      irqs(4);
      cmp("rising word", 16'hc300, word);
      rd(`CSI_ADDR_RXBUF0, v, ok);
      cmp("rising pin word", 16'h9600, v);
      run <= 1'h0;
      repeat (20) @(posedge clk);
      rise <= 1'h0;
      wr(`CSI_ADDR_CTRL, 16'h0000, ok);
      run <= 1'h1;
    end
  endtask
  task t_idle;
    begin
      wr(`CSI_ADDR_TSE, 16'h0000, ok);
      wr(`CSI_ADDR_CTRL, 16'h0040, ok);
      irqs(2);
      cmp("tristate", 16'h0000, {15'h0000, sdo_oe});
      wr(`CSI_ADDR_CTRL, 16'h0000, ok);
      irqs(2);
      cmp("idle low", 16'h0002, {14'h0000, sdo_oe, sdo});
    end
  endtask
  task results;
    begin
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    t_regs;
    t_loop;
    t_zero;
    t_pin;
    t_rise;
    t_idle;
    results;
  end
  // The limit allows several times the expected run of about twenty frames.
  initial begin
    #400000;
    err_total = err_total + 1;
    results;
  end
endmodule // tb
